/* hdl/laai_pkg.sv */
/*
 * Shared definitions for the logic / add-immediate execution slice:
 * instruction field positions, opcodes, widths and the write-back carrier.
 * Assumes 32-bit instruction words and a 32-entry general register file.
 */
`default_nettype none

package laai_pkg;

   // =====================================================================
   // Word and index widths
   // =====================================================================
   localparam int unsigned XLEN = 32;      // Datapath width
   localparam int unsigned IDXW = 5;       // Register index width
   localparam int unsigned IMMW = 16;      // Immediate width
   localparam int unsigned OPW = 6;        // Primary opcode width

   // =====================================================================
   // Field positions (low bit of each field)
   // =====================================================================
   localparam int unsigned FLD_A_LSB = 27;   // First register index, 31:27
   localparam int unsigned FLD_B_LSB = 22;   // Second register index, 26:22
   localparam int unsigned FLD_C_LSB = 17;   // Result index, 21:17 (R-type)
   localparam int unsigned FLD_OPX_LSB = 11; // Extended opcode, 16:11
   localparam int unsigned FLD_SH_LSB = 6;   // Shift field, 10:6
   localparam int unsigned FLD_IMM_LSB = 6;  // Immediate, 21:6 (I-type)
   localparam int unsigned FLD_OP_LSB = 0;   // Primary opcode, 5:0

   // =====================================================================
   // Opcodes
   // =====================================================================
   localparam logic [5:0] OP_RTYPE = 6'h3a;    // Register-type group
   localparam logic [5:0] OPX_AND = 6'h0e;     // Extended code of AND
   localparam logic [5:0] OP_ANDHI = 6'h2c;    // AND into high halfword
   localparam logic [5:0] OP_ADDI_DFLT = 6'h01; // Add-immediate, overridable
   localparam logic [4:0] SHIFT_ZERO = 5'h00;  // Required shift field value
   localparam logic [15:0] HALF_ZERO = 16'h0000; // Low half of the andhi mask

   // =====================================================================
   // Write-back carrier toward the register file
   // =====================================================================
   typedef struct packed {
      logic valid;             // One-cycle write strobe
      logic [4:0] index;       // Destination register index
      logic [31:0] data;       // Value to write
   } laai_wb_t;

   // Reset value of the carrier
   localparam laai_wb_t WB_RESET = '{valid: 1'b0, index: 5'h00, data: 32'h0000_0000};

endpackage : laai_pkg

`default_nettype wire

/* hdl/laai_exec.sv */
/*
 * Execute slice for register AND, AND-high-immediate and add-immediate.
 * Takes an instruction word and both operand values from the decoder and
 * register file in the same clock domain, and returns one registered
 * write-back per accepted word, one cycle later.
 * Assumes the register file presents the values indexed by the first and
 * second register fields of the word alongside it.
 */
`timescale 1ns/100ps
`default_nettype none

module laai_exec #(
   parameter logic [5:0] ADDI_OPCODE = laai_pkg::OP_ADDI_DFLT // Add-immediate code
) (
   input wire logic clk_i,                       // 100 MHz core clock
   input wire logic reset_i,                     // Asynchronous, active high
   input wire logic issue_valid_i,               // Word and operands valid
   input wire logic [31:0] instr_i,              // Instruction word
   input wire logic [31:0] first_source_reg_i,   // Value of register at field A
   input wire logic [31:0] second_operand_reg_i, // Value of register at field B
   output var laai_pkg::laai_wb_t wb_o,          // Registered write-back
   output logic illegal_o                        // Registered: word not handled
);

   // =====================================================================
   // Operation selection
   // =====================================================================
   typedef enum logic [3:0] {
      LAAI_OP_NONE  = 4'b0001,   // Nothing to do
      LAAI_OP_AND   = 4'b0010,   // Register AND
      LAAI_OP_ANDHI = 4'b0100,   // AND with high-half mask
      LAAI_OP_ADDI  = 4'b1000    // Add sign-extended immediate
   } laai_op_t;

   // Field extraction, used by the decoder only; the checks slice the word directly
   function automatic logic [4:0] fld5(input logic [31:0] w, input int unsigned lsb);
      fld5 = w[lsb +: 5];
   endfunction : fld5

   function automatic logic [5:0] fld6(input logic [31:0] w, input int unsigned lsb);
      fld6 = w[lsb +: 6];
   endfunction : fld6

   function automatic logic [15:0] fld_imm(input logic [31:0] w);
      fld_imm = w[laai_pkg::FLD_IMM_LSB +: 16];
   endfunction : fld_imm

   // Decoded fields
   logic [5:0] opcode;              // Primary opcode
   logic [5:0] opx;                 // Extended opcode
   logic [4:0] shift_fld;           // Shift field, must be zero for AND
   // First index is looked up by the register file, never here
   logic [4:0] idx_second;          // Second register index
   logic [4:0] idx_result;          // R-type result index
   logic [15:0] immediate_halfword; // Raw immediate
   laai_op_t op_sel;                // Selected operation

   // =====================================================================
   // Decode
   // =====================================================================
   // Field positions follow the I-type layout for immediates
   always_comb begin
      opcode = fld6(instr_i, laai_pkg::FLD_OP_LSB);
      // Field A arrives already resolved into first_source_reg_i
      idx_second = fld5(instr_i, laai_pkg::FLD_B_LSB);
      immediate_halfword = fld_imm(instr_i);
      opx = fld6(instr_i, laai_pkg::FLD_OPX_LSB);
      shift_fld = fld5(instr_i, laai_pkg::FLD_SH_LSB);
      idx_result = fld5(instr_i, laai_pkg::FLD_C_LSB);
   end

   // Opcode to operation; an R-type AND with nonzero shift is refused
   always_comb begin
      op_sel = LAAI_OP_NONE;
      if (opcode == laai_pkg::OP_RTYPE) begin
         // Register group: extended code and zero shift both needed
         if (opx == laai_pkg::OPX_AND && shift_fld == laai_pkg::SHIFT_ZERO) begin
            op_sel = LAAI_OP_AND;
         end
      end else if (opcode == laai_pkg::OP_ANDHI) begin
         op_sel = LAAI_OP_ANDHI;
      end else if (opcode == ADDI_OPCODE) begin
         op_sel = LAAI_OP_ADDI;
      end
   end

   // =====================================================================
   // Result computation
   // =====================================================================
   logic [31:0] hi_mask;      // Immediate over a zero low half
   logic [31:0] imm_sext;     // Sign-extended immediate
   logic [31:0] result;       // Selected result
   logic [4:0] dest_idx;      // Selected destination

   // Mask and extension are built unconditionally; cheap and glitch-free
   always_comb begin
      hi_mask = {immediate_halfword, laai_pkg::HALF_ZERO};
      imm_sext = {{16{immediate_halfword[15]}}, immediate_halfword};
   end

   // Operation mux; the add drops its carry, software detects it itself
   always_comb begin
      result = 32'h0000_0000;
      dest_idx = 5'h00;
      case (op_sel)
         LAAI_OP_AND: begin
            result = first_source_reg_i & second_operand_reg_i;
            dest_idx = idx_result;
         end
         LAAI_OP_ANDHI: begin
            result = first_source_reg_i & hi_mask;
            dest_idx = idx_second;
         end
         LAAI_OP_ADDI: begin
            result = first_source_reg_i + imm_sext;
            dest_idx = idx_second;
         end
         LAAI_OP_NONE: begin
            result = 32'h0000_0000;
            dest_idx = 5'h00;
         end
         default: begin
            result = 32'h0000_0000;
            dest_idx = 5'h00;
         end
      endcase
   end

   // =====================================================================
   // Write-back register
   // =====================================================================
   laai_pkg::laai_wb_t wb_r;    // Registered carrier
   laai_pkg::laai_wb_t wb_nxt;  // Its next value
   logic illegal_r;             // Registered refusal flag
   logic illegal_nxt;           // Its next value

   // Strobe only for recognised words; data held otherwise to save toggles
   always_comb begin
      wb_nxt = wb_r;
      wb_nxt.valid = 1'b0;
      illegal_nxt = 1'b0;
      if (issue_valid_i) begin
         if (op_sel != LAAI_OP_NONE) begin
            wb_nxt.valid = 1'b1;
            wb_nxt.index = dest_idx;
            wb_nxt.data = result;
         end else begin
            illegal_nxt = 1'b1;
         end
      end
   end

   // Carrier flop
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wb_r <= laai_pkg::WB_RESET;
      end else begin
         wb_r <= wb_nxt;
      end
   end

   // Refusal flop
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         illegal_r <= 1'b0;
      end else begin
         illegal_r <= illegal_nxt;
      end
   end

   assign wb_o = wb_r;
   assign illegal_o = illegal_r;

   // =====================================================================
   // Checks
   // =====================================================================
   AST_AND_RESULT: assert property (@(posedge clk_i) disable iff (reset_i)
      (issue_valid_i && instr_i[5:0] == 6'h3a && instr_i[16:11] == 6'h0e && instr_i[10:6] == 5'h00)
      |=> (wb_o.valid && wb_o.data == ($past(first_source_reg_i) & $past(second_operand_reg_i))
           && wb_o.index == $past(instr_i[21:17])))
      else $error("register AND result or index wrong");

   AST_AND_SHIFT_REFUSED: assert property (@(posedge clk_i) disable iff (reset_i)
      (issue_valid_i && instr_i[5:0] == 6'h3a && instr_i[10:6] != 5'h00)
      |=> (!wb_o.valid && illegal_o))
      else $error("R-type AND with nonzero shift was executed");

   AST_ANDHI_RESULT: assert property (@(posedge clk_i) disable iff (reset_i)
      (issue_valid_i && instr_i[5:0] == 6'h2c)
      |=> (wb_o.valid && wb_o.data[15:0] == 16'h0000
           && wb_o.data[31:16] == ($past(first_source_reg_i[31:16]) & $past(instr_i[21:6]))))
      else $error("andhi result wrong");

   AST_ANDHI_DEST: assert property (@(posedge clk_i) disable iff (reset_i)
      (issue_valid_i && instr_i[5:0] == 6'h2c) |=> (wb_o.index == $past(instr_i[26:22]) && !illegal_o))
      else $error("andhi destination wrong");

   AST_ADDI_DEST: assert property (@(posedge clk_i) disable iff (reset_i)
      (issue_valid_i && instr_i[5:0] == ADDI_OPCODE) |=> (wb_o.valid && wb_o.index == $past(instr_i[26:22])))
      else $error("addi destination wrong");

   AST_ADDI_SUM: assert property (@(posedge clk_i) disable iff (reset_i)
      (issue_valid_i && instr_i[5:0] == ADDI_OPCODE)
      |=> (wb_o.data == $past(first_source_reg_i) + {{16{$past(instr_i[21])}}, $past(instr_i[21:6])}))
      else $error("addi sum wrong");

   AST_IDLE_QUIET: assert property (@(posedge clk_i) disable iff (reset_i)
      !issue_valid_i |=> (!wb_o.valid && !illegal_o))
      else $error("write-back without an issued word");

   AST_ONE_OUTCOME: assert property (@(posedge clk_i) disable iff (reset_i)
      issue_valid_i |=> (wb_o.valid != illegal_o))
      else $error("issued word had no single outcome");

endmodule : laai_exec

`default_nettype wire

/* tb/laai_rf_model.sv */
/*
 * Register file model that faces the execute slice: it presents the
 * operands that fields A and B select, and it takes the slice's write-backs.
 * Assumes one clock, and a bench that preloads the array at time zero.
 */
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Register file model
// =====================================================================
module laai_rf_model (
   input wire logic clk_i,              // Core clock
   input wire logic [31:0] instr_i,     // Word being issued
   input wire laai_pkg::laai_wb_t wb_i, // Write-back from the slice
   output logic [31:0] first_o,         // Value at field A
   output logic [31:0] second_o         // Value at field B
);
   logic [31:0] regs [32]; // Plain always below, so the bench may preload it

   // Operands follow the index fields with no delay
   assign first_o = regs[instr_i[31:27]];
   assign second_o = regs[instr_i[26:22]];

   // Register zero stays constant, so its writes are dropped here
   always @(posedge clk_i) begin
      if (wb_i.valid && wb_i.index != 5'h00) begin
         regs[wb_i.index] <= wb_i.data;
      end
   end
endmodule : laai_rf_model

`default_nettype wire

/* tb/tb.sv */
/*
 * Self-checking bench for the execute slice: random and fixed words,
 * back to back, checked against a mirror of the register file.
 * Assumes the slice answers exactly one cycle after taking a word.
 */
`timescale 1ns/100ps
`default_nettype none

module tb;
   // =====================================================================
   // Signals and bookkeeping
   // =====================================================================
   logic clk, reset_i, issue_valid_i; // Clock, reset, issue strobe
   logic [31:0] instr_i, a, b; // Word and operands
   laai_pkg::laai_wb_t wb_o, held; // Output, and last write-back seen
   logic illegal_o; // Refusal pulse
   logic [31:0] seed, w, mirror [32]; // Random state, word, register mirror
   logic [38:0] e0, e1; // Pending expectations {illegal, wb}
   logic [1:0] k0, k1; // Kinds of pending words
   int fails, comparisons; // Verdict counters
   // Corners: carry, sign, empty mask, other R code, AND with nonzero shift
   logic [31:0] corner [5] = '{{5'd1, 5'd2, 16'hffff, laai_pkg::OP_ADDI_DFLT},
      {5'd1, 5'd3, 16'h8000, laai_pkg::OP_ADDI_DFLT}, {5'd1, 5'd4, 16'h0000, laai_pkg::OP_ANDHI},
      {5'd1, 5'd1, 5'd5, 6'h31, 5'h00, laai_pkg::OP_RTYPE},
      {5'd1, 5'd1, 5'd6, laai_pkg::OPX_AND, 5'h04, laai_pkg::OP_RTYPE}};

   laai_exec #(.ADDI_OPCODE(laai_pkg::OP_ADDI_DFLT)) DUT (.clk_i(clk), .reset_i(reset_i),
      .issue_valid_i(issue_valid_i), .instr_i(instr_i), .first_source_reg_i(a),
      .second_operand_reg_i(b), .wb_o(wb_o), .illegal_o(illegal_o));
   laai_rf_model u_rf (.clk_i(clk), .instr_i(instr_i), .wb_i(wb_o), .first_o(a), .second_o(b));

   // =====================================================================
   // Helpers
   // =====================================================================
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Result of one issue, or an idle slot; wb index/data unused when not valid
   function automatic logic [38:0] expect_of(input logic v, input logic [31:0] x, opa, opb);
      if (!v) return 39'h0;
      if (x[5:0] == laai_pkg::OP_RTYPE && x[16:11] == laai_pkg::OPX_AND && x[10:6] == 5'h00) begin
         return {2'b01, x[21:17], opa & opb};
      end else if (x[5:0] == laai_pkg::OP_ANDHI) begin
         return {2'b01, x[26:22], opa & {x[21:6], 16'h0000}};
      end else if (x[5:0] == laai_pkg::OP_ADDI_DFLT) begin
         return {2'b01, x[26:22], opa + {{16{x[21]}}, x[21:6]}};
      end
      return {1'b1, 38'h0};
   endfunction : expect_of

   task automatic compare_wb(input string n, input laai_pkg::laai_wb_t e, input laai_pkg::laai_wb_t g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : compare_wb

   task automatic compare_bit(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask : compare_bit

   task automatic final_report();
      if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   // =====================================================================
   // Clock and timeout
   // =====================================================================
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Main run is about 2000 cycles, so this ceiling only catches a hang
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      final_report();
   end

   // =====================================================================
   // Main sequence: check due result, update mirror, drive next word
   // =====================================================================
   initial begin
      reset_i = 1'b1;
      issue_valid_i = 1'b0;
      instr_i = 32'h0000_0000;
      seed = 32'he432b67e;
      fails = 0;
      comparisons = 0;
      e0 = 39'h0;
      e1 = 39'h0;
      k0 = 2'd3;
      k1 = 2'd3;
      held = laai_pkg::WB_RESET;
      for (int i = 0; i < 32; i++) begin
         seed = lfsr(seed);
         mirror[i] = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'hffff_ffff : seed;
         u_rf.regs[i] = mirror[i];
      end
      repeat (2) @(posedge clk);
      reset_i <= 1'b0;
      // Two extra idle slots let the last two words be checked too
      for (int c = 0; c < 2002; c++) begin
         // Idle or refused slots leave index and data as last written
         if (e1[37]) held = e1[37:0];
         case (k1)
            2'd0: compare_wb("and_wb", held, wb_o);
            2'd1: compare_wb("andhi_wb", held, wb_o);
            2'd2: compare_wb("addi_wb", held, wb_o);
            default: compare_wb("idle_wb", {1'b0, held.index, held.data}, wb_o);
         endcase
         compare_bit("illegal", e1[38], illegal_o);
         if (e1[37] && e1[36:32] != 5'h00) mirror[e1[36:32]] = e1[31:0];
         e1 = e0;
         k1 = k0;
         seed = lfsr(seed);
         k0 = seed[1:0];
         case (k0)
            2'd0: w = {seed[31:17], laai_pkg::OPX_AND, 5'h00, laai_pkg::OP_RTYPE};
            2'd1: w = {seed[31:6], laai_pkg::OP_ANDHI};
            2'd2: w = {seed[31:6], laai_pkg::OP_ADDI_DFLT};
            default: w = seed[2] ? seed : {seed[31:11], seed[10:6] | 5'h01, laai_pkg::OP_RTYPE};
         endcase
         if (c < 5) w = corner[c];
         if (c < 5) k0 = (c == 2) ? 2'd1 : (c >= 3) ? 2'd3 : 2'd2;
         e0 = expect_of(c < 5 || (c < 2000 && seed[4:2] != 3'h0), w, mirror[w[31:27]], mirror[w[26:22]]);
         if (!e0[37]) k0 = 2'd3;
         issue_valid_i <= (c < 5 || (c < 2000 && seed[4:2] != 3'h0));
         instr_i <= w;
         @(posedge clk);
      end
      final_report();
   end
endmodule : tb

`default_nettype wire
